// File: include/mtc_pkg.sv
// Constants, field layout, register map and state codes of the multiplex transfer channel.
// Assumes a 125 MHz system clock and a 16-bit memory word with 14-bit addresses.
package mtc_pkg;
	// ********************************************************
	// Widths and counts
	// ********************************************************
	localparam int MAX_CHAN = 8;
	localparam int CHAN_IDX_W = 3;
	localparam int WORD_W = 16;
	localparam int MADDR_W = 14;
	localparam int APB_AW = 12;
	localparam int APB_DW = 32;
	// ********************************************************
	// Control word layout (bit 1 of the word is the most significant)
	// ********************************************************
	localparam int DIR_BIT = 15;
	localparam int MODE_BIT = 14;
	localparam logic [MADDR_W-1:0] CTL_BASE_ADDR = 14'h0008;
	// ********************************************************
	// Timing
	// ********************************************************
	localparam real XFER_TIME_US = 6.8;
	localparam real CLK_PERIOD_NS = 8.0;
	localparam real XFER_CYCLES_EXACT = XFER_TIME_US * 1000.0 / CLK_PERIOD_NS;
	localparam int XFER_CYCLES_RND = int'(XFER_CYCLES_EXACT);
	localparam int XFER_CYCLES = (real'(XFER_CYCLES_RND) < XFER_CYCLES_EXACT) ?
		XFER_CYCLES_RND + 1 : XFER_CYCLES_RND;
	// Cycles after select before the device word is taken through the synchroniser
	localparam int DIN_SETTLE = 3;
	// ********************************************************
	// Register map
	// ********************************************************
	localparam logic [APB_AW-1:0] REG_CTRL = 12'h000;
	localparam logic [APB_AW-1:0] REG_STATUS = 12'h004;
	localparam logic [APB_AW-1:0] REG_DONE = 12'h008;
	localparam logic [APB_AW-1:0] REG_IRQ_EN = 12'h00C;
	localparam int CTRL_EN_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_HOG_BIT = 1;
	localparam int STAT_INC_BIT = 2;
	localparam int STAT_CHAN_LSB = 4;
	localparam logic CTRL_EN_RESET = 1'b0;
	// ********************************************************
	// Sequencer states
	// ********************************************************
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_RD_EVEN = 7'h02,
		ST_RD_ODD = 7'h04,
		ST_WR_EVEN = 7'h08,
		ST_XFER = 7'h10,
		ST_MEM = 7'h20,
		ST_FINISH = 7'h40
	} mtc_state_t;
endpackage : mtc_pkg

// File: rtl/mtc_prio_pick.sv
// Lowest-numbered pending request picker.
// Assumes the request vector comes from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module mtc_prio_pick #(
	parameter int N = mtc_pkg::MAX_CHAN
) (
	input wire logic [N-1:0] req,
	output logic valid,
	output logic [mtc_pkg::CHAN_IDX_W-1:0] idx
);
	import mtc_pkg::*;
	generate
		if (N < 1 || N > (1 << CHAN_IDX_W)) begin : g_bad_n
			$error("mtc_prio_pick: N out of range");
		end
	endgenerate
	// ********************************************************
	// Search from the top so the lowest index wins
	// ********************************************************
	always_comb begin
		valid = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				valid = 1'b1;
				idx = CHAN_IDX_W'(i);
			end
		end
	end
endmodule : mtc_prio_pick
`default_nettype wire

// File: rtl/mtc_slot_timer.sv
// Down counter that times the processor slot of one word transfer.
// Assumes start is a one-cycle pulse from the sequencer.
`timescale 1ns/100ps
`default_nettype none
module mtc_slot_timer #(
	parameter int CYCLES = mtc_pkg::XFER_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic start,
	output logic done
);
	import mtc_pkg::*;
	localparam int CW = $clog2(CYCLES + 1);
	generate
		if (CYCLES < 1) begin : g_bad_cycles
			$error("mtc_slot_timer: CYCLES must be at least one");
		end
	endgenerate
	logic [CW-1:0] cnt_q;
	// ********************************************************
	// Counter
	// ********************************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_q <= '0;
		end else if (start) begin
			cnt_q <= CW'(CYCLES - 1);
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - CW'(1);
		end
	end
	assign done = (cnt_q == '0) && !start;
endmodule : mtc_slot_timer
`default_nettype wire

// File: rtl/mtc_channel.sv
// Multiplex transfer channel: cycle-stealing one-word transfers for up to eight subchannels.
// Assumes a CPU that reports instruction boundaries and obeys HOLD_CPU, and a handshaked memory.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module mtc_channel #(
	parameter int N_CHAN = mtc_pkg::MAX_CHAN
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [mtc_pkg::APB_AW-1:0] PADDR,
	input wire logic [mtc_pkg::APB_DW-1:0] PWDATA,
	output logic [mtc_pkg::APB_DW-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic INSTR_BOUNDARY,
	output logic STEAL_REQ,
	output logic HOLD_CPU,
	output logic MEM_REQ,
	output logic MEM_WE,
	output logic [mtc_pkg::MADDR_W-1:0] MEM_ADDR,
	output logic [mtc_pkg::WORD_W-1:0] MEM_WDATA,
	input wire logic [mtc_pkg::WORD_W-1:0] MEM_RDATA,
	input wire logic MEM_ACK,
	input wire logic [N_CHAN-1:0] TRANSFER_REQUEST_LINE,
	output logic [N_CHAN-1:0] TRANSFER_SELECT_LINE,
	output logic END_OF_RANGE_LINE,
	input wire logic EXT_STOP,
	input wire logic [mtc_pkg::WORD_W-1:0] IO_DATA_IN,
	output logic [mtc_pkg::WORD_W-1:0] IO_DATA_OUT,
	output logic IO_STROBE,
	output logic IO_INPUT_DIR,
	output logic PI_DEFER,
	input wire logic CLK_INC_REQ,
	output logic CLK_INC_GRANT,
	output logic STD_INT_REQ
);
	import mtc_pkg::*;
	generate
		if (N_CHAN < 1 || N_CHAN > MAX_CHAN) begin : g_bad_chan
			$error("mtc_channel: N_CHAN out of range");
		end
	endgenerate

	// ********************************************************
	// Functions
	// ********************************************************
	function automatic logic [MADDR_W-1:0] ctl_addr(input logic [CHAN_IDX_W-1:0] ch,
		input logic odd);
		ctl_addr = CTL_BASE_ADDR + MADDR_W'({ch, odd});
	endfunction : ctl_addr

	function automatic logic [N_CHAN-1:0] chan_mask(input logic [CHAN_IDX_W-1:0] ch);
		chan_mask = '0;
		chan_mask[ch] = 1'b1;
	endfunction : chan_mask

	// ********************************************************
	// Signals
	// ********************************************************
	logic [N_CHAN-1:0] req_meta_q, req_sync_q, armed_q, pend;
	logic stop_meta_q, stop_sync_q;
	logic [WORD_W-1:0] din_meta_q, din_sync_q;
	logic pick_valid;
	logic [CHAN_IDX_W-1:0] pick_idx;
	mtc_state_t st_q;
	logic [CHAN_IDX_W-1:0] chan_q;
	logic [WORD_W-1:0] ctl_q;
	logic [MADDR_W-1:0] final_q, cur_q;
	logic last_q, hog_q, hold_q, steal_q;
	logic enable_q, pready_q, pslverr_q;
	logic [APB_DW-1:0] prdata_q, rd_data;
	logic [N_CHAN-1:0] done_q, irq_en_q, done_set, done_clr;
	logic inc_pend_q, inc_grant_q, inc_fire, pi_defer_q, std_int_q;
	logic mem_req_q, mem_we_q;
	logic [MADDR_W-1:0] mem_addr_q;
	logic [WORD_W-1:0] mem_wdata_q, dout_q;
	logic [N_CHAN-1:0] sel_q;
	logic eor_q, strobe_q, dir_q;
	logic [1:0] xwait_q;
	logic start, slot_done, apb_setup, apb_wr, mapped;
	int slot_cnt_q;

	// ********************************************************
	// Pin synchronisers
	// ********************************************************
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			req_meta_q <= '0;
			req_sync_q <= '0;
			stop_meta_q <= 1'b0;
			stop_sync_q <= 1'b0;
			din_meta_q <= '0;
			din_sync_q <= '0;
		end else begin
			req_meta_q <= TRANSFER_REQUEST_LINE;
			req_sync_q <= req_meta_q;
			stop_meta_q <= EXT_STOP;
			stop_sync_q <= stop_meta_q;
			din_meta_q <= IO_DATA_IN;
			din_sync_q <= din_meta_q;
		end
	end

	// ********************************************************
	// Arbitration
	// ********************************************************
	assign pend = req_sync_q & armed_q & {N_CHAN{enable_q}};

	mtc_prio_pick #(
		.N(N_CHAN)
	) u_pick (
		.req(pend),
		.valid(pick_valid),
		.idx(pick_idx)
	);

	assign start = (st_q == ST_IDLE) && pick_valid && (INSTR_BOUNDARY || hold_q);
	assign inc_fire = inc_pend_q && (st_q == ST_IDLE) && !hold_q && !pick_valid;

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			armed_q <= '0;
			steal_q <= 1'b0;
			pi_defer_q <= 1'b0;
			inc_pend_q <= 1'b0;
			inc_grant_q <= 1'b0;
		end else begin
			armed_q <= (armed_q | ~req_sync_q) & ~(start ? chan_mask(pick_idx) : '0);
			steal_q <= pick_valid && !hold_q;
			pi_defer_q <= pick_valid || hold_q;
			inc_pend_q <= (inc_pend_q && !inc_fire) || CLK_INC_REQ;
			inc_grant_q <= inc_fire;
		end
	end

	// ********************************************************
	// Slot timer
	// ********************************************************
	mtc_slot_timer #(
		.CYCLES(XFER_CYCLES)
	) u_slot (
		.clk_sys(CLK_SYS),
		.reset(RESET),
		.start(start),
		.done(slot_done)
	);

	// ********************************************************
	// Transfer sequencer
	// ********************************************************
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			st_q <= ST_IDLE;
			chan_q <= '0;
			ctl_q <= '0;
			final_q <= '0;
			cur_q <= '0;
			last_q <= 1'b0;
			hog_q <= 1'b0;
			hold_q <= 1'b0;
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_addr_q <= '0;
			mem_wdata_q <= '0;
			sel_q <= '0;
			eor_q <= 1'b0;
			strobe_q <= 1'b0;
			dir_q <= 1'b0;
			dout_q <= '0;
			xwait_q <= '0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (start) begin
						chan_q <= pick_idx;
						hold_q <= 1'b1;
						mem_req_q <= 1'b1;
						mem_we_q <= 1'b0;
						mem_addr_q <= ctl_addr(pick_idx, 1'b0);
						st_q <= ST_RD_EVEN;
					end else if (!pick_valid && !hog_q) begin
						hold_q <= 1'b0;
					end
				end
				ST_RD_EVEN: begin
					if (MEM_ACK) begin
						ctl_q <= MEM_RDATA;
						mem_addr_q <= ctl_addr(chan_q, 1'b1);
						st_q <= ST_RD_ODD;
					end
				end
				ST_RD_ODD: begin
					if (MEM_ACK) begin
						final_q <= MEM_RDATA[MADDR_W-1:0];
						cur_q <= ctl_q[MADDR_W-1:0] + MADDR_W'(1);
						mem_we_q <= 1'b1;
						mem_addr_q <= ctl_addr(chan_q, 1'b0);
						mem_wdata_q <= {ctl_q[DIR_BIT], ctl_q[MODE_BIT],
							ctl_q[MADDR_W-1:0] + MADDR_W'(1)};
						st_q <= ST_WR_EVEN;
					end
				end
				ST_WR_EVEN: begin
					if (MEM_ACK) begin
						mem_req_q <= 1'b0;
						mem_we_q <= 1'b0;
						sel_q <= chan_mask(chan_q);
						dir_q <= ctl_q[DIR_BIT];
						last_q <= (cur_q == final_q);
						xwait_q <= '0;
						st_q <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (xwait_q != 2'(DIN_SETTLE)) begin
						xwait_q <= xwait_q + 2'h1;
					end else begin
						mem_req_q <= 1'b1;
						mem_we_q <= dir_q;
						mem_addr_q <= cur_q;
						mem_wdata_q <= din_sync_q;
						st_q <= ST_MEM;
					end
				end
				ST_MEM: begin
					if (MEM_ACK) begin
						mem_req_q <= 1'b0;
						mem_we_q <= 1'b0;
						if (!dir_q) begin
							dout_q <= MEM_RDATA;
						end
						strobe_q <= 1'b1;
						eor_q <= last_q;
						st_q <= ST_FINISH;
					end
				end
				ST_FINISH: begin
					strobe_q <= 1'b0;
					if (slot_done) begin
						sel_q <= '0;
						eor_q <= 1'b0;
						hog_q <= ctl_q[MODE_BIT] && !last_q;
						st_q <= ST_IDLE;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
			if (stop_sync_q) begin
				hog_q <= 1'b0;
			end
		end
	end

	// ********************************************************
	// APB slave
	// ********************************************************
	assign apb_setup = PSEL && PENABLE && !pready_q;
	assign apb_wr = PSEL && PENABLE && pready_q && PWRITE;
	assign mapped = (PADDR == REG_CTRL) || (PADDR == REG_STATUS) ||
		(PADDR == REG_DONE) || (PADDR == REG_IRQ_EN);

	always_comb begin
		rd_data = '0;
		case (PADDR)
			REG_CTRL: rd_data[CTRL_EN_BIT] = enable_q;
			REG_STATUS: begin
				rd_data[STAT_BUSY_BIT] = (st_q != ST_IDLE);
				rd_data[STAT_HOG_BIT] = hog_q;
				rd_data[STAT_INC_BIT] = inc_pend_q;
				rd_data[STAT_CHAN_LSB +: CHAN_IDX_W] = chan_q;
			end
			REG_DONE: rd_data[N_CHAN-1:0] = done_q;
			REG_IRQ_EN: rd_data[N_CHAN-1:0] = irq_en_q;
			default: rd_data = '0;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
			enable_q <= CTRL_EN_RESET;
			irq_en_q <= '0;
		end else begin
			pready_q <= apb_setup;
			if (apb_setup) begin
				prdata_q <= rd_data;
				pslverr_q <= !mapped;
			end
			if (apb_wr && PADDR == REG_CTRL) begin
				enable_q <= PWDATA[CTRL_EN_BIT];
			end
			if (apb_wr && PADDR == REG_IRQ_EN) begin
				irq_en_q <= PWDATA[N_CHAN-1:0];
			end
		end
	end

	// ********************************************************
	// Block-complete flags and subchannel interrupt
	// ********************************************************
	assign done_set = (st_q == ST_FINISH && slot_done && last_q) ? chan_mask(chan_q) : '0;
	assign done_clr = (apb_wr && PADDR == REG_DONE) ? PWDATA[N_CHAN-1:0] : '0;

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			done_q <= '0;
			std_int_q <= 1'b0;
		end else begin
			done_q <= (done_q & ~done_clr) | done_set;
			std_int_q <= |(done_q & irq_en_q);
		end
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign STEAL_REQ = steal_q;
	assign HOLD_CPU = hold_q;
	assign MEM_REQ = mem_req_q;
	assign MEM_WE = mem_we_q;
	assign MEM_ADDR = mem_addr_q;
	assign MEM_WDATA = mem_wdata_q;
	assign TRANSFER_SELECT_LINE = sel_q;
	assign END_OF_RANGE_LINE = eor_q;
	assign IO_DATA_OUT = dout_q;
	assign IO_STROBE = strobe_q;
	assign IO_INPUT_DIR = dir_q;
	assign PI_DEFER = pi_defer_q;
	assign CLK_INC_GRANT = inc_grant_q;
	assign STD_INT_REQ = std_int_q;

	// ********************************************************
	// Checks
	// ********************************************************
	always_ff @(posedge CLK_SYS) begin
		if (RESET || start) begin
			slot_cnt_q <= 0;
		end else if (slot_cnt_q < XFER_CYCLES) begin
			slot_cnt_q <= slot_cnt_q + 1;
		end
	end

	property p_start_boundary;
		@(posedge CLK_SYS) disable iff (RESET)
		$rose(HOLD_CPU) |-> $past(INSTR_BOUNDARY);
	endproperty
	a_start_boundary: assert property (p_start_boundary)
		else $error("service began inside an instruction");

	property p_one_strobe;
		@(posedge CLK_SYS) disable iff (RESET)
		IO_STROBE |=> !IO_STROBE ##1 (!IO_STROBE || $past(st_q) == ST_MEM);
	endproperty
	a_one_strobe: assert property (p_one_strobe)
		else $error("word strobe longer than one cycle");

	property p_slot_time;
		@(posedge CLK_SYS) disable iff (RESET)
		(st_q == ST_FINISH && slot_done) |-> slot_cnt_q >= XFER_CYCLES - 1;
	endproperty
	a_slot_time: assert property (p_slot_time)
		else $error("transfer slot shorter than the word time");

	property p_eor_selected;
		@(posedge CLK_SYS) disable iff (RESET)
		END_OF_RANGE_LINE |-> (TRANSFER_SELECT_LINE != '0) && last_q;
	endproperty
	a_eor_selected: assert property (p_eor_selected)
		else $error("end of range without selected last word");

	property p_select_onehot;
		@(posedge CLK_SYS) disable iff (RESET)
		$onehot0(TRANSFER_SELECT_LINE) && (TRANSFER_SELECT_LINE == '0 || HOLD_CPU);
	endproperty
	a_select_onehot: assert property (p_select_onehot)
		else $error("select lines not one-hot or not during a steal");

	property p_hog_hold;
		@(posedge CLK_SYS) disable iff (RESET)
		hog_q |-> HOLD_CPU;
	endproperty
	a_hog_hold: assert property (p_hog_hold)
		else $error("processor released during block mode");

	property p_pi_defer;
		@(posedge CLK_SYS) disable iff (RESET)
		pick_valid |=> PI_DEFER;
	endproperty
	a_pi_defer: assert property (p_pi_defer)
		else $error("priority interrupt not deferred by pending transfer");

	property p_inc_blocked;
		@(posedge CLK_SYS) disable iff (RESET)
		CLK_INC_GRANT |-> !$past(hold_q) && !$past(pick_valid);
	endproperty
	a_inc_blocked: assert property (p_inc_blocked)
		else $error("clock increment granted over a transfer");

	property p_lowest_first;
		@(posedge CLK_SYS) disable iff (RESET)
		start |=> (chan_q == $past(pick_idx)) &&
			(($past(pend) & (chan_mask(chan_q) - N_CHAN'(1))) == '0);
	endproperty
	a_lowest_first: assert property (p_lowest_first)
		else $error("lower pending subchannel was skipped");

	property p_stop_hog;
		@(posedge CLK_SYS) disable iff (RESET)
		stop_sync_q |=> !hog_q;
	endproperty
	a_stop_hog: assert property (p_stop_hog)
		else $error("external stop did not end block mode");

	property p_done_flag;
		@(posedge CLK_SYS) disable iff (RESET)
		(st_q == ST_FINISH && slot_done && last_q) |=> done_q[$past(chan_q)];
	endproperty
	a_done_flag: assert property (p_done_flag)
		else $error("block complete flag not set");
endmodule : mtc_channel
`default_nettype wire

// File: dv/mtc_dev_model.sv
// Device partner: request, data and end-of-range behaviour of eight subchannel devices.
// Assumes go pulses from the bench and the channel's select and end-of-range lines.
`timescale 1ns/100ps
`default_nettype none
module mtc_dev_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] go,
	input wire logic hold_off,
	input wire logic [7:0] sel,
	input wire logic eor,
	output logic [7:0] req,
	output logic [15:0] dout
);
	logic [7:0] armed_q;
	logic [7:0] sel_q;
	logic [7:0] cnt_q [8];
	always_ff @(posedge clk) begin
		sel_q <= sel;
		dout <= rst ? 16'h0F0F : ~dout;
		for (int i = 0; i < 8; i++) begin
			if (rst) begin
				armed_q[i] <= 1'b0;
				req[i] <= 1'b0;
				cnt_q[i] <= 8'h00;
			end else begin
				if (go[i]) armed_q[i] <= 1'b1;
				if (sel[i] && eor) armed_q[i] <= 1'b0;
				if (sel_q[i] && !sel[i]) cnt_q[i] <= cnt_q[i] + 8'h01;
				if (sel[i]) dout <= {4'hD, 1'b0, 3'(i), cnt_q[i]};
				req[i] <= (armed_q[i] || go[i]) && !sel[i] && !sel_q[i] && !hold_off
					&& !(sel[i] && eor);
			end
		end
	end
endmodule : mtc_dev_model
`default_nettype wire

// File: dv/multiplexed_word_transfer_channel_tb_top.sv
// Testbench top: APB, CPU boundary, memory and clock-increment sides of the channel.
// Assumes the device partner model on the subchannel lines.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module multiplexed_word_transfer_channel_tb_top;
	import mtc_pkg::*;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [APB_DW-1:0] pwdata = '0, prdata;
	logic pready, pslverr, instr_b = 1'b0, steal, hold, mem_req, mem_we, mem_ack = 1'b0;
	logic [MADDR_W-1:0] mem_addr;
	logic [WORD_W-1:0] mem_wdata, mem_rdata = '0, io_in, io_out;
	logic [7:0] req, sel, sel_q = '0, go = '0;
	logic eor, eor_q = 1'b0, ext_stop = 1'b0, hold_off = 1'b0, strobe, io_dir, pi_defer;
	logic inc_req = 1'b0, grant, std_int, hold_q = 1'b0, hb_q = 1'b0, in_blk = 1'b0;
	logic [WORD_W-1:0] mem [1 << MADDR_W];
	logic [WORD_W-1:0] outq [$];
	logic [7:0] order [$];
	int err_total = 0, check_count = 0, cyc = 0, last_rise = 0, eors = 0, grants = 0, gap = 0;
	int strobes [8] = '{default: 0};
	mtc_channel i_mtc_channel (.CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .INSTR_BOUNDARY(instr_b), .STEAL_REQ(steal), .HOLD_CPU(hold),
		.MEM_REQ(mem_req), .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
		.MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack), .TRANSFER_REQUEST_LINE(req),
		.TRANSFER_SELECT_LINE(sel), .END_OF_RANGE_LINE(eor), .EXT_STOP(ext_stop),
		.IO_DATA_IN(io_in), .IO_DATA_OUT(io_out), .IO_STROBE(strobe), .IO_INPUT_DIR(io_dir),
		.PI_DEFER(pi_defer), .CLK_INC_REQ(inc_req), .CLK_INC_GRANT(grant), .STD_INT_REQ(std_int));
	mtc_dev_model i_mtc_dev_model (.clk(clk), .rst(rst), .go(go), .hold_off(hold_off),
		.sel(sel), .eor(eor), .req(req), .dout(io_in));
	initial forever #4 clk = ~clk;
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		$display("Run timed out");
		complete_run();
	end
	// ********************************
	// Memory, boundary and monitors
	// ********************************
	always @(posedge clk) begin
		cyc <= cyc + 1;
		instr_b <= (cyc % 4 == 2);
		mem_ack <= mem_req && !mem_ack && !rst;
		mem_rdata <= (mem_req && !mem_ack) ? mem[mem_addr] : ~mem_rdata;
		if (mem_req && mem_ack && mem_we) mem[mem_addr] <= mem_wdata;
		hold_q <= hold;
		hb_q <= instr_b;
		sel_q <= sel;
		eor_q <= eor;
		if (!rst) begin
			if (hold && !hold_q) `CHK("boundary", 1'b1, hb_q)
			if (hold) `CHK("pi_defer", 1'b1, pi_defer)
			if (hold) `CHK("steal", !hold_q, steal)
			if (grant) `CHK("grant_hold", 1'b0, hold_q)
			if (grant) grants++;
			if (in_blk && !hold) gap++;
			if (eor && !eor_q) eors++;
			if (sel != 0 && sel_q == 0) begin
				order.push_back(sel);
				if (last_rise != 0) `CHK("slot", 1'b1, cyc - last_rise >= XFER_CYCLES)
				last_rise = cyc;
			end
			if (strobe) for (int i = 0; i < 8; i++) if (sel[i]) begin
				strobes[i]++;
				if (!io_dir) outq.push_back(io_out);
			end
		end
	end
	// ********************************
	// Tasks
	// ********************************
	task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] wd,
		output logic [APB_DW-1:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
		logic [APB_DW-1:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rdv(input logic [APB_AW-1:0] a, output logic [APB_DW-1:0] r);
		logic e;
		apb(1'b0, a, '0, r, e);
	endtask : rdv
	task automatic setup(input int ch, input logic dir, input logic blk,
		input logic [13:0] s, input logic [13:0] f);
		mem[int'(CTL_BASE_ADDR) + 2 * ch] = {dir, blk, s - 14'h0001};
		mem[int'(CTL_BASE_ADDR) + 2 * ch + 1] = {dir, blk, f};
		for (int a = s; a <= f; a++) mem[a] = 16'h5000 + 16'(a);
	endtask : setup
	task automatic start(input logic [7:0] m);
		go <= m;
		@(posedge clk);
		go <= 8'h00;
	endtask : start
	task automatic wait_done(input logic [APB_DW-1:0] m);
		logic [APB_DW-1:0] r;
		do begin
			repeat (64) @(posedge clk);
			rdv(REG_DONE, r);
		end while ((r & m) !== m);
		while (sel !== 8'h00) @(posedge clk);
	endtask : wait_done
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	// ********************************
	// Tests
	// ********************************
	initial begin
		logic [APB_DW-1:0] r;
		logic e;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rdv(REG_CTRL, r);
		`CHK("ctrl_reset", 32'h0, r)
		apb(1'b0, 12'h010, '0, r, e);
		`CHK("unmapped_err", 1'b1, e)
		$display("Test reset done");
		setup(0, 1'b0, 1'b0, 14'h0100, 14'h0102);
		wr(REG_CTRL, 32'h1);
		start(8'h01);
		wait_done(32'h1);
		`CHK("words_ch0", 3, strobes[0])
		for (int k = 0; k < 3; k++) `CHK("out_word", 16'h5100 + 16'(k), outq[k])
		`CHK("eor_count", 1, eors)
		`CHK("ctl_write_back", 14'h0102, mem[8][13:0])
		`CHK("hold_shared", 1'b0, hold)
		$display("Test output block done");
		setup(1, 1'b1, 1'b0, 14'h0200, 14'h0201);
		setup(2, 1'b1, 1'b0, 14'h0300, 14'h0301);
		order.delete();
		start(8'h06);
		wait_done(32'h6);
		`CHK("first_sel", 8'h02, order[0])
		`CHK("second_sel", 8'h04, order[1])
		for (int k = 0; k < 2; k++) begin
			`CHK("in_word_c1", 16'hD100 + 16'(k), mem[16'h0200 + k])
			`CHK("in_word_c2", 16'hD200 + 16'(k), mem[16'h0300 + k])
		end
		`CHK("in_no_out", 3, outq.size())
		$display("Test priority done");
		wr(REG_IRQ_EN, 32'h8);
		setup(3, 1'b0, 1'b1, 14'h0400, 14'h0402);
		start(8'h08);
		while (sel[3] !== 1'b1) @(posedge clk);
		in_blk <= 1'b1;
		grants <= 0;
		inc_req <= 1'b1;
		@(posedge clk);
		inc_req <= 1'b0;
		while (sel[3] !== 1'b0) @(posedge clk);
		repeat (2) @(posedge clk);
		rdv(REG_STATUS, r);
		`CHK("hog_active", 1'b1, r[STAT_HOG_BIT])
		`CHK("inc_pending", 1'b1, r[STAT_INC_BIT])
		while (eor !== 1'b1) @(posedge clk);
		in_blk <= 1'b0;
		wait_done(32'h8);
		`CHK("hold_gap", 0, gap)
		`CHK("words_ch3", 3, strobes[3])
		`CHK("irq_set", 1'b1, std_int)
		wr(REG_DONE, 32'h8);
		repeat (4) @(posedge clk);
		`CHK("irq_clr", 1'b0, std_int)
		`CHK("inc_grant", 1, grants)
		$display("Test block mode done");
		setup(4, 1'b0, 1'b1, 14'h0500, 14'h0507);
		start(8'h10);
		while (strobes[4] == 0) @(posedge clk);
		hold_off <= 1'b1;
		ext_stop <= 1'b1;
		repeat (900) @(posedge clk);
		rdv(REG_STATUS, r);
		`CHK("stop_hog", 1'b0, r[STAT_HOG_BIT])
		`CHK("stop_hold", 1'b0, hold)
		`CHK("stop_words", 1, strobes[4])
		ext_stop <= 1'b0;
		$display("Test external stop done");
		complete_run();
	end
endmodule : multiplexed_word_transfer_channel_tb_top
`default_nettype wire
